// ===== logic/core_irq_enable.sv
// interrupt enable, flag and vectoring logic with a wishbone register port
//
// Functional notes
// [R1] global enable gates every request
// [R2] group enable gates all peripheral sources
// [R3] timer zero enable gates its flag
// [R4] pin enable gates the external flag
// [R5] port enable plus per-pin mask gate change
// [R6] timer zero flag sets on overflow, sticky
// [R7] external flag cleared only by software
// [R8] port change flag sets on change, sticky
// [R9] software loads timer before clearing flag
// [R10] enable register a holds eight peripheral enables
// [R11] enable register b implements bit zero only
// [R12] unimplemented bits read zero, ignore writes
// [R13] flags set regardless of any enable but the per-pin port mask
// [R14] take: flush, clear global, push, vector
// [R15] return pops address, sets global enable
// [R16] edge select picks rising or falling edge
// [R17] request from enabled core or peripheral flag
// [R18] hardware set beats software clear
`timescale 1ns/100ps
`include "irq_ctrl_regs.svh"
module core_irq_enable
   import irq_ctrl_pkg::*;
(
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        reset,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   // event sources
   input  wire logic        timer_zero_overflow,
   input  wire logic        ext_irq_pin,
   input  wire logic [7:0]  port_pins,
   input  wire logic [7:0]  periph_flags_a,
   input  wire logic        periph_flags_b,
   // sequencer side
   input  wire pc_type      current_pc,
   input  wire logic        return_from_interrupt,
   input  wire pc_type      stack_pop_pc,
   output logic             irq_request,
   output logic             fetch_flush,
   output logic             stack_push,
   output pc_type           stack_push_pc,
   output logic             stack_pop,
   output logic             pc_load,
   output pc_type           pc_load_value,
   // interrupt output
   output logic             irq_out
);
   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic          global_irq_enable;        // global enable
      logic [3:0]    core_en;    // group, timer, pin, port enables
      logic [7:0]    pie_a;      // peripheral enables a
      logic          pie_b;      // peripheral enable b
      logic [7:0]    port_mask;  // per-pin change enables
      logic          edge_sel;   // external edge select
      logic [1:0]    irq_mask;   // interrupt output mask
      logic          ack;        // bus acknowledge
      logic [7:0]    rdata;      // read data
      seq_state_type state;      // vectoring sequencer
      pc_type        ret_pc;     // captured return address
      logic          flush;      // sequencer pulses
      logic          push;
      logic          pop;
      logic          load;
      pc_type        load_pc;    // value for pc load
   } st_type;
   st_type s_q;
   st_type s_d;

   evt_if ev ();                 // event pulses
   logic [2:0] core_flags;       // timer, pin, port flags
   logic [1:0] stat;             // interrupt status
   logic       bus_req;          // new bus access
   logic       wr_ok;            // write hits low byte lane
   logic       wr_ctrl;          // write to control register
   logic       wr_stat;          // write to status register
   logic       core_req;         // core source pending and enabled
   logic       per_req;          // peripheral source pending and enabled
   logic       take;             // interrupt taken this cycle
   logic       ret;              // return handled this cycle
   logic [1:0] stat_set;         // status events

   // ----------------------------------------------------------------------
   // event detection and flags
   // ----------------------------------------------------------------------
   event_detect u_events (
      .sys_clk             (sys_clk),
      .reset               (reset),
      .timer_zero_overflow (timer_zero_overflow),
      .ext_irq_pin         (ext_irq_pin),
      .port_pins           (port_pins),
      .edge_select_option  (s_q.edge_sel),
      .port_change_mask    (s_q.port_mask),
      .ev                  (ev)
   );

   // timer, pin and port flags stay set until software writes them
   sticky_bits #(.W(3)) u_core_flags (
      .sys_clk      (sys_clk),
      .reset        (reset),
      .set_bits     ({ev.tmr_evt, ev.pin_evt, ev.port_evt}), // [R6] [R7] [R8]
      .wr_en        (wr_ctrl),
      .wr_one_clear (1'b0),
      .wr_data      (wb_dat_i[2:0]),
      .flags        (core_flags)
   );

   // interrupt status, write one to clear
   sticky_bits #(.W(2)) u_status (
      .sys_clk      (sys_clk),
      .reset        (reset),
      .set_bits     (stat_set),
      .wr_en        (wr_stat),
      .wr_one_clear (1'b1),
      .wr_data      (wb_dat_i[1:0]),
      .flags        (stat)
   );

   // ----------------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------------
   always_comb begin
      bus_req = wb_cyc_i & wb_stb_i & ~s_q.ack;
      wr_ok   = bus_req & wb_we_i & wb_sel_i[0];
      wr_ctrl = wr_ok & (wb_adr_i == `OFS_CORE_CTRL);
      wr_stat = wr_ok & (wb_adr_i == `OFS_IRQ_STATUS);
   end

   // ----------------------------------------------------------------------
   // request combine
   // ----------------------------------------------------------------------
   always_comb begin
      core_req = (s_q.core_en[2] & core_flags[2]) |       // [R3]
                 (s_q.core_en[1] & core_flags[1]) |       // [R4]
                 (s_q.core_en[0] & core_flags[0]);        // [R5]
      per_req  = s_q.core_en[3] &                         // [R2]
                 ((|(s_q.pie_a & periph_flags_a)) |       // [R10]
                  (s_q.pie_b & periph_flags_b));          // [R11]
      irq_request = s_q.global_irq_enable & (core_req | per_req);       // [R1] [R17]
      ret  = (s_q.state == seq_idle_type_s) & return_from_interrupt;
      take = (s_q.state == seq_idle_type_s) & ~ret & irq_request;
      stat_set = '0;
      stat_set[`STAT_TAKEN]  = take;
      stat_set[`STAT_RETURN] = ret;
   end

   // ----------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.ack   = bus_req;            // one wait state, then ack
      s_d.flush = 1'b0;
      s_d.push  = 1'b0;
      s_d.pop   = 1'b0;
      s_d.load  = 1'b0;

      // register writes, low byte lane only
      if (wr_ok) begin
         case (wb_adr_i)
            `OFS_CORE_CTRL: begin
               s_d.global_irq_enable     = wb_dat_i[`BIT_GLOBAL_EN];
               s_d.core_en = wb_dat_i[`BIT_GROUP_EN:`BIT_PORT_EN];
            end
            `OFS_PIE_A: begin
               s_d.pie_a = wb_dat_i[7:0];              // [R10]
            end
            `OFS_PIE_B: begin
               s_d.pie_b = wb_dat_i[`BIT_PIE_B_CCP];   // [R11] [R12]
            end
            `OFS_PORT_MASK: begin
               s_d.port_mask = wb_dat_i[7:0];
            end
            `OFS_OPTION: begin
               s_d.edge_sel = wb_dat_i[`BIT_EDGE_SEL];
            end
            `OFS_IRQ_MASK: begin
               s_d.irq_mask = wb_dat_i[1:0];
            end
            default: begin
               // status handled by its own flags, others ignored
            end
         endcase
      end

      // register reads, unused bits zero
      s_d.rdata = 8'h00;                                  // [R12]
      if (bus_req & ~wb_we_i) begin
         case (wb_adr_i)
            `OFS_CORE_CTRL: begin
               s_d.rdata = {s_q.global_irq_enable, s_q.core_en, core_flags};
            end
            `OFS_PIE_A: begin
               s_d.rdata = s_q.pie_a;
            end
            `OFS_PIE_B: begin
               s_d.rdata = {7'h00, s_q.pie_b};            // [R12]
            end
            `OFS_PORT_MASK: begin
               s_d.rdata = s_q.port_mask;
            end
            `OFS_OPTION: begin
               s_d.rdata[`BIT_EDGE_SEL] = s_q.edge_sel;
            end
            `OFS_IRQ_STATUS: begin
               s_d.rdata = {6'h00, stat};
            end
            `OFS_IRQ_MASK: begin
               s_d.rdata = {6'h00, s_q.irq_mask};
            end
            default: begin
               s_d.rdata = 8'h00;      // unmapped reads zero
            end
         endcase
      end

      // vectoring sequencer
      case (s_q.state)
         seq_idle_type_s: begin
            if (ret) begin
               s_d.pop     = 1'b1;                        // [R15]
               s_d.load    = 1'b1;
               s_d.load_pc = stack_pop_pc;
               s_d.global_irq_enable     = 1'b1;                        // [R15]
            end else if (take) begin
               s_d.flush  = 1'b1;                         // [R14]
               s_d.global_irq_enable    = 1'b0;                         // [R14]
               s_d.ret_pc = current_pc;
               s_d.state  = seq_flush_type_s;
            end
         end
         seq_flush_type_s: begin
            s_d.push  = 1'b1;                             // [R14]
            s_d.state = seq_push_type_s;
         end
         seq_push_type_s: begin
            s_d.load    = 1'b1;                           // [R14]
            s_d.load_pc = `IRQ_VECTOR;
            s_d.state   = seq_jump_type_s;
         end
         seq_jump_type_s: begin
            s_d.state = seq_idle_type_s;  // settle one cycle
         end
         default: begin
            s_d.state = seq_idle_type_s;
         end
      endcase
   end

   // ----------------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         s_q           <= '0;
         s_q.core_en   <= `RST_CORE_EN;
         s_q.pie_a     <= `RST_PIE_A;
         s_q.pie_b     <= `RST_PIE_B;
         s_q.port_mask <= `RST_PORT_MASK;
         s_q.edge_sel  <= `RST_EDGE_SEL;
         s_q.irq_mask  <= `RST_IRQ_MASK;
         s_q.state     <= seq_idle_type_s;
         s_q.ret_pc    <= `RST_PC;
         s_q.load_pc   <= `RST_PC;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   assign wb_ack_o      = s_q.ack;
   assign wb_dat_o      = {24'h000000, s_q.rdata};
   assign fetch_flush   = s_q.flush;
   assign stack_push    = s_q.push;
   assign stack_push_pc = s_q.ret_pc;
   assign stack_pop     = s_q.pop;
   assign pc_load       = s_q.load;
   assign pc_load_value = s_q.load_pc;
   assign irq_out       = |(stat & s_q.irq_mask);
endmodule // core_irq_enable

// ===== logic/event_detect.sv
// turns timer, pin and port inputs into registered event pulses
`timescale 1ns/100ps
module event_detect
   import irq_ctrl_pkg::*;
(
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       reset,
   // sources
   input  wire logic       timer_zero_overflow,
   input  wire logic       ext_irq_pin,
   input  wire logic [7:0] port_pins,
   // configuration
   input  wire logic       edge_select_option,
   input  wire logic [7:0] port_change_mask,
   // event pulses
   evt_if.src              ev
);
   typedef struct packed {
      logic       pin_prev;   // last pin level
      logic [7:0] port_prev;  // last port levels
      logic       primed;     // history valid after reset
      logic       tmr;        // registered pulses
      logic       pin;
      logic       port;
   } st_type;
   st_type s_q;
   st_type s_d;

   // ------------------------------------------------------------
   // edge compare against the previous sample
   // ------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.pin_prev  = ext_irq_pin;
      s_d.port_prev = port_pins;
      s_d.primed    = 1'b1;
      s_d.tmr       = timer_zero_overflow;
      // rising edge when set, falling when clear
      if (edge_select_option) begin
         s_d.pin = s_q.primed & ext_irq_pin & ~s_q.pin_prev;  // [R16]
      end else begin
         s_d.pin = s_q.primed & ~ext_irq_pin & s_q.pin_prev;  // [R16]
      end
      // only pins with their mask bit set count
      s_d.port = s_q.primed &
                 (|((port_pins ^ s_q.port_prev) & port_change_mask)); // [R5]
   end

   // state register
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign ev.tmr_evt  = s_q.tmr;
   assign ev.pin_evt  = s_q.pin;
   assign ev.port_evt = s_q.port;
endmodule // event_detect

// ===== logic/evt_if.sv
// event pulses from the edge detector to the flag logic
`timescale 1ns/100ps
interface evt_if;
   logic tmr_evt;   // timer zero rolled over
   logic pin_evt;   // valid edge on external pin
   logic port_evt;  // enabled port pin changed
   modport src (output tmr_evt, output pin_evt, output port_evt);
   modport snk (input tmr_evt, input pin_evt, input port_evt);
endinterface

// ===== logic/irq_ctrl_pkg.sv
// types shared by the interrupt enable logic
package irq_ctrl_pkg;
   typedef logic [12:0] pc_type;     // program counter word
   typedef enum logic [1:0] {
      seq_idle_type_s  = 2'b00,      // waiting for a request
      seq_flush_type_s = 2'b01,      // flush fetch, drop global enable
      seq_push_type_s  = 2'b10,      // push return address
      seq_jump_type_s  = 2'b11       // load vector
   } seq_state_type;
endpackage

// ===== logic/irq_ctrl_regs.svh
// register offsets, bit positions, reset values of the interrupt enable logic
`ifndef IRQ_CTRL_REGS_SVH
`define IRQ_CTRL_REGS_SVH
// ----------------------------------------------------------------------
// byte offsets on the register bus
// ----------------------------------------------------------------------
`define OFS_CORE_CTRL    8'h00
`define OFS_PIE_A        8'h04
`define OFS_PIE_B        8'h08
`define OFS_PORT_MASK    8'h0c
`define OFS_OPTION       8'h10
`define OFS_IRQ_STATUS   8'h14
`define OFS_IRQ_MASK     8'h18
// ----------------------------------------------------------------------
// core control, option and enable b register fields
// ----------------------------------------------------------------------
`define BIT_GLOBAL_EN    7
`define BIT_GROUP_EN     6
`define BIT_TIMER_ZERO_COUNT_EN      5
`define BIT_PIN_EN       4
`define BIT_PORT_EN      3
`define BIT_TIMER_ZERO_COUNT_FLAG    2
`define BIT_PIN_FLAG     1
`define BIT_PORT_FLAG    0
`define BIT_EDGE_SEL     6
`define BIT_PIE_B_CCP    0
// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RST_CORE_EN      4'h0
`define RST_CORE_FLAGS   3'h0
`define RST_PIE_A        8'h00
`define RST_PIE_B        1'h0
`define RST_PORT_MASK    8'h00
`define RST_EDGE_SEL     1'h1
`define RST_IRQ_MASK     2'h0
`define RST_PC           13'h0000
// ----------------------------------------------------------------------
// sequencer constants and interrupt status bits
// ----------------------------------------------------------------------
`define IRQ_VECTOR       13'h0004
`define STAT_TAKEN       0
`define STAT_RETURN      1
`endif

// ===== logic/sticky_bits.sv
// sticky flag bits: hardware sets, software loads or clears
`timescale 1ns/100ps
module sticky_bits
   import irq_ctrl_pkg::*;
#(
   parameter int W = 3
) (
   // clock and reset
   input  wire logic         sys_clk,
   input  wire logic         reset,
   // hardware set pulses
   input  wire logic [W-1:0] set_bits,
   // software access
   input  wire logic         wr_en,
   input  wire logic         wr_one_clear,
   input  wire logic [W-1:0] wr_data,
   // flag state
   output logic [W-1:0]      flags
);
   typedef struct packed {
      logic [W-1:0] q;  // flag bits
   } st_type;
   st_type s_q;
   st_type s_d;

   // ------------------------------------------------------------
   // next state: write first, then hardware set wins
   // ------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      if (wr_en) begin
         if (wr_one_clear) begin
            s_d.q = s_q.q & ~wr_data;   // write one to clear
         end else begin
            s_d.q = wr_data;            // plain load
         end
      end
      s_d.q = s_d.q | set_bits;         // [R18] [R13]
   end

   // state register
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign flags = s_q.q;
endmodule // sticky_bits

// ===== tb/core_irq_enable_monitor.sv
// port assertions for the interrupt enable logic
`timescale 1ns/100ps
`include "irq_ctrl_regs.svh"
module core_irq_enable_monitor
   import irq_ctrl_pkg::*;
(
   // clock and reset
   input wire logic        sys_clk,
   input wire logic        reset,
   // register bus
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   // event sources
   input wire logic        timer_zero_overflow,
   input wire logic        ext_irq_pin,
   input wire logic [7:0]  port_pins,
   input wire logic [7:0]  periph_flags_a,
   input wire logic        periph_flags_b,
   // sequencer side
   input wire pc_type      current_pc,
   input wire logic        return_from_interrupt,
   input wire pc_type      stack_pop_pc,
   input wire logic        irq_request,
   input wire logic        fetch_flush,
   input wire logic        stack_push,
   input wire pc_type      stack_push_pc,
   input wire logic        stack_pop,
   input wire logic        pc_load,
   input wire pc_type      pc_load_value,
   input wire logic        irq_out
);
   // ----------------------------------------------------------------------
   // one clock domain, reset disables every check
   // ----------------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   a_ack_answers: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus request left without ack");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   a_global_off: assert property (wb_ack_o && wb_we_i && wb_sel_i[0]
      && wb_adr_i == `OFS_CORE_CTRL && !wb_dat_i[`BIT_GLOBAL_EN]
      && !return_from_interrupt |=> !irq_request)
      else $error("request with global enable clear");
   a_take_order: assert property ($rose(fetch_flush) |=> stack_push
      ##1 (pc_load && pc_load_value == `IRQ_VECTOR))
      else $error("take sequence out of order");
   a_take_cause: assert property (fetch_flush |-> $past(irq_request))
      else $error("flush without request");
   a_push_pc: assert property (stack_push |-> stack_push_pc == $past(current_pc, 2))
      else $error("pushed pc wrong");
   a_flush_gap: assert property (fetch_flush |=> !fetch_flush [*3])
      else $error("take restarted too soon");
   a_return_pop: assert property (stack_pop |-> $past(return_from_interrupt)
      && pc_load && pc_load_value == stack_pop_pc)
      else $error("return did not reload popped pc");
endmodule // core_irq_enable_monitor

bind core_irq_enable core_irq_enable_monitor u_core_irq_enable_monitor (
   .sys_clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
   .wb_dat_o, .wb_ack_o, .timer_zero_overflow, .ext_irq_pin, .port_pins,
   .periph_flags_a, .periph_flags_b, .current_pc, .return_from_interrupt, .stack_pop_pc,
   .irq_request, .fetch_flush, .stack_push, .stack_push_pc, .stack_pop, .pc_load,
   .pc_load_value, .irq_out
);

// ===== tb/core_irq_enable_tb.sv
// self-checking bench for the interrupt enable logic
`timescale 1ns/100ps
`include "irq_ctrl_regs.svh"
module core_irq_enable_tb
   import irq_ctrl_pkg::*;
;
   logic        sys_clk, reset, wb_cyc, wb_stb, wb_we, wb_ack, tmr, pin, pfb, ret_req;
   logic [7:0]  wb_adr, port, pfa, c, pa;
   logic [31:0] wb_dat, wb_rdat;
   logic        irq_request, fetch_flush, stack_push, stack_pop, pc_load, irq_out, ret, pb, e;
   pc_type      cur_pc, pop_pc, push_pc, load_pc;
   int          n_take, t0, n_fail, checked, cycles;
   // gating table: control, peripheral flags a, peripheral flag b, takes expected
   logic [17:0] tab [10] = '{{8'ha4, 8'h00, 1'b0, 1'b1}, {8'h24, 8'h00, 1'b0, 1'b0},
      {8'h84, 8'h00, 1'b0, 1'b0}, {8'h92, 8'h00, 1'b0, 1'b1}, {8'h82, 8'h00, 1'b0, 1'b0},
      {8'h89, 8'h00, 1'b0, 1'b1}, {8'h81, 8'h00, 1'b0, 1'b0}, {8'hc0, 8'h10, 1'b0, 1'b1},
      {8'h80, 8'h10, 1'b0, 1'b0}, {8'hc0, 8'h20, 1'b1, 1'b1}};

   core_irq_enable u_core_irq_enable (.sys_clk, .reset, .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'h1), .wb_dat_i(wb_dat),
      .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .timer_zero_overflow(tmr), .ext_irq_pin(pin),
      .port_pins(port), .periph_flags_a(pfa), .periph_flags_b(pfb), .current_pc(cur_pc),
      .return_from_interrupt(ret), .stack_pop_pc(pop_pc), .irq_request, .fetch_flush,
      .stack_push, .stack_push_pc(push_pc), .stack_pop, .pc_load, .pc_load_value(load_pc),
      .irq_out);
   sequencer_model u_sequencer_model (.sys_clk, .reset, .stack_push, .stack_push_pc(push_pc),
      .stack_pop, .pc_load, .pc_load_value(load_pc), .ret_req, .current_pc(cur_pc),
      .return_from_interrupt(ret), .stack_pop_pc(pop_pc), .n_take);

   // ----------------------------------------------------------------------
   // clock, timeout and tasks
   // ----------------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   // cut a hang short
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 3000) begin
         n_fail++;
         complete_run();
      end
   end
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   // one classic cycle, held until ack
   task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] d,
      output logic [7:0] q);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= adr;
      wb_dat <= {24'h0, d};
      do @(posedge sys_clk); while (wb_ack !== 1'b1);
      q = wb_rdat[7:0];
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic wr(input logic [7:0] adr, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b1, adr, d, q);
   endtask
   task automatic rd_chk(input string name, input logic [7:0] adr, input logic [7:0] exp);
      logic [7:0] q;
      bus(1'b0, adr, 8'h00, q);
      chk(name, exp, q);
   endtask
   task automatic ticks(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // ----------------------------------------------------------------------
   // test sequence
   // ----------------------------------------------------------------------
   initial begin
      {reset, wb_cyc, wb_stb, wb_we, tmr, pin, pfb, ret_req} = 8'h80;
      {wb_adr, port, pfa, wb_dat} = '0;
      {n_fail, checked, cycles} = '0;
      ticks(5);
      reset <= 1'b0;
      ticks(1);
      // reset values and unmapped space
      rd_chk("control", `OFS_CORE_CTRL, 8'h00);
      rd_chk("enable a", `OFS_PIE_A, 8'h00);
      rd_chk("enable b", `OFS_PIE_B, 8'h00);
      rd_chk("unmapped", 8'h1c, 8'h00);
      wr(`OFS_PIE_A, 8'hff);
      rd_chk("enable a", `OFS_PIE_A, 8'hff);
      wr(`OFS_PIE_B, 8'hff);
      rd_chk("enable b", `OFS_PIE_B, 8'h01);
      wr(8'h1c, 8'hff);
      rd_chk("unmapped", 8'h1c, 8'h00);
      // timer flag sets with global and core enables off and stays set
      tmr <= 1'b1;
      ticks(1);
      tmr <= 1'b0;
      ticks(3);
      rd_chk("timer flag", `OFS_CORE_CTRL, 8'h04);
      // an overflow landing on a clearing write survives
      tmr <= 1'b1;
      ticks(1);
      tmr <= 1'b0;
      wr(`OFS_CORE_CTRL, 8'h00);
      rd_chk("set beats clear", `OFS_CORE_CTRL, 8'h04);
      wr(`OFS_CORE_CTRL, 8'h00);
      rd_chk("timer cleared", `OFS_CORE_CTRL, 8'h00);
      // pin edges under both edge selections
      pin <= 1'b1;
      ticks(3);
      rd_chk("pin rise", `OFS_CORE_CTRL, 8'h02);
      wr(`OFS_CORE_CTRL, 8'h00);
      pin <= 1'b0;
      ticks(3);
      rd_chk("pin fall", `OFS_CORE_CTRL, 8'h00);
      wr(`OFS_OPTION, 8'h00);
      pin <= 1'b1;
      ticks(3);
      rd_chk("pin rise", `OFS_CORE_CTRL, 8'h00);
      pin <= 1'b0;
      ticks(3);
      rd_chk("pin fall", `OFS_CORE_CTRL, 8'h02);
      wr(`OFS_CORE_CTRL, 8'h00);
      // port change only through masked pins
      wr(`OFS_PORT_MASK, 8'h01);
      port <= 8'h02;
      ticks(3);
      rd_chk("port masked", `OFS_CORE_CTRL, 8'h00);
      port <= 8'h03;
      ticks(3);
      rd_chk("port change", `OFS_CORE_CTRL, 8'h01);
      wr(`OFS_CORE_CTRL, 8'h00);
      // request gating, counted as vector loads
      wr(`OFS_PIE_A, 8'h10);
      for (int i = 0; i < 10; i++) begin
         {c, pa, pb, e} = tab[i];
         pfa <= pa;
         pfb <= pb;
         t0 = n_take;
         wr(`OFS_CORE_CTRL, c);
         ticks(6);
         chk("take count", {7'h0, e}, 8'(n_take - t0));
         wr(`OFS_CORE_CTRL, 8'h00);
      end
      // taken status, mask and interrupt line
      rd_chk("status", `OFS_IRQ_STATUS, 8'h01);
      chk("irq masked", 8'h00, {7'h0, irq_out});
      wr(`OFS_IRQ_MASK, 8'h01);
      chk("irq raised", 8'h01, {7'h0, irq_out});
      wr(`OFS_IRQ_STATUS, 8'h01);
      chk("irq cleared", 8'h00, {7'h0, irq_out});
      // return sets the global enable again
      ret_req <= 1'b1;
      ticks(1);
      ret_req <= 1'b0;
      ticks(3);
      rd_chk("global after return", `OFS_CORE_CTRL, 8'h80);
      rd_chk("return status", `OFS_IRQ_STATUS, 8'h02);
      complete_run();
   end
endmodule // core_irq_enable_tb

// ===== tb/sequencer_model.sv
// behavioural instruction sequencer facing the interrupt logic
`timescale 1ns/100ps
module sequencer_model
   import irq_ctrl_pkg::*;
(
   // clock and reset
   input  wire logic   sys_clk,
   input  wire logic   reset,
   // from the interrupt logic
   input  wire logic   stack_push,
   input  wire pc_type stack_push_pc,
   input  wire logic   stack_pop,
   input  wire logic   pc_load,
   input  wire pc_type pc_load_value,
   // bench asks for a return
   input  wire logic   ret_req,
   // toward the interrupt logic
   output pc_type      current_pc,
   output logic        return_from_interrupt,
   output pc_type      stack_pop_pc,
   // count of vector loads
   output int          n_take
);
   // program counter, one-entry stack and return pulse
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         current_pc <= 13'h0100;
         return_from_interrupt <= 1'b0;
         stack_pop_pc <= 13'h1fff;
         n_take <= 0;
      end else begin
         current_pc <= pc_load ? pc_load_value : current_pc + 13'h0001;
         return_from_interrupt <= ret_req;
         // save on push, spoil the slot once popped
         if (stack_push) begin
            stack_pop_pc <= stack_push_pc;
         end else if (stack_pop) begin
            stack_pop_pc <= ~stack_pop_pc;
         end
         // a vector load that is not a return
         if (pc_load && !stack_pop && pc_load_value == 13'h0004) begin
            n_take <= n_take + 1;
         end
      end
   end
endmodule // sequencer_model
